// >>> eeprom_pkg.sv
// Purpose: Shared constants and types for the two-wire serial memory target.
// Assumes: clk_sys at 40 MHz; the serial clock comes from the bus controller.
// Notes: Times are given in their own unit and converted to cycles here.
package eeprom_pkg;
  localparam int PAGE_BYTES = 64;
  localparam int PAGES = 512;
  localparam int MEM_BYTES = PAGE_BYTES * PAGES;
  localparam int ADDR_W = 15;
  localparam int COL_W = 6;
  localparam int PAGE_W = 9;
  localparam int COUNT_W = 7;
  localparam int TIMER_W = 18;
  localparam logic [COUNT_W-1:0] FULL_PAGE = 7'h40;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int CLK_SYS_NS = 25;
  localparam int WR_TIME_MS = 5;
  localparam int WR_TIME_NS = WR_TIME_MS * 1000000;
  // Longest time, so the cycle count rounds down
  localparam int WR_CYCLES = WR_TIME_NS / CLK_SYS_NS;
  typedef logic [TIMER_W-1:0] timer_t;
  typedef logic [COUNT_W-1:0] count_t;
  typedef logic [COL_W-1:0] col_t;
  typedef enum logic [2:0] {
    st_idle, st_select, st_addr_hi, st_addr_lo, st_write, st_read
  } link_state_e;
  typedef enum logic {prog_idle, prog_run} prog_state_e;
endpackage

// >>> eeprom_target.sv
// Purpose: Target side of a byte-wide serial nonvolatile memory on a two-wire bus.
// Assumes: serial_clk is the controller's clock and may stop between frames.
// Notes: Start and stop are caught by flops clocked on data line edges.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01 - Sample data on rising, drive on falling
// RULE_02 - Data line is only pulled low or released
// RULE_03 - Selected only when straps match select bits
// RULE_04 - Floating select straps read as low
// RULE_05 - Write protect high blocks all array writes
// RULE_06 - Floating write protect reads as low
// RULE_07 - 512 pages of 64 bytes, 15-bit address
// RULE_08 - Accept full and partial page writes
// RULE_09 - Self-timed programming finishes within 5 ms
// RULE_10 - Data falling with clock high means start
// RULE_11 - Data rising with clock high means stop
// RULE_12 - Pull data low on ninth clock to acknowledge
// RULE_13 - Select byte last bit: high read, low write
// RULE_14 - Ignore selection while programming is pending
// RULE_15 - Page writes wrap within the current page
module eeprom_target #(
  parameter int PROG_CYCLES = eeprom_pkg::WR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic sda_in,
  input wire logic select_strap_msb,
  input wire logic select_strap_mid,
  input wire logic select_strap_lsb,
  input wire logic write_protect,
  output logic sda_out,
  output logic sda_oe,
  output logic write_busy
);
  prog_if pif ();

  // Array and page buffer; neither is reset
  logic [7:0] mem [0:eeprom_pkg::MEM_BYTES-1];
  logic [7:0] page_buf [0:eeprom_pkg::PAGE_BYTES-1];

  // Data-edge domain: start and stop detectors
  logic start_tog, next_start_tog;
  logic stop_tog, next_stop_tog;

  always_comb begin
    next_start_tog = serial_clk ? ~start_tog : start_tog; // see RULE_10
    next_stop_tog = serial_clk ? ~stop_tog : stop_tog; // see RULE_11
  end

  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tog <= 1'b0;
    end else begin
      start_tog <= next_start_tog;
    end
  end

  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_tog <= 1'b0;
    end else begin
      stop_tog <= next_stop_tog;
    end
  end

  // Link domain
  logic [2:0] chip_select_straps;
  logic [2:0] strap_s1, strap_s;
  logic done_tog;
  logic done_s1, done_s;
  eeprom_pkg::link_state_e state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [eeprom_pkg::ADDR_W-1:0] addr, next_addr;
  eeprom_pkg::col_t col0, next_col0;
  eeprom_pkg::count_t wr_cnt, next_wr_cnt;
  logic ack, next_ack;
  logic start_seen, next_start_seen;
  logic done_seen, next_done_seen;
  logic buf_we;
  logic [7:0] got;
  logic [7:0] rd_byte;
  logic [3:0] rd_pos;
  logic next_sda_oe;

  // Unconnected straps are pulled low at the pad, so plain levels suffice
  assign chip_select_straps = {select_strap_msb, select_strap_mid, select_strap_lsb}; // see RULE_04

  // Straps and the done toggle pass two link-clock flops before use
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1 <= 3'h0;
      strap_s <= 3'h0;
      done_s1 <= 1'b0;
      done_s <= 1'b0;
    end else begin
      strap_s1 <= chip_select_straps;
      strap_s <= strap_s1;
      done_s1 <= done_tog;
      done_s <= done_s1;
    end
  end

  assign got = {shift[6:0], sda_in}; // see RULE_01
  // The array only changes while the link refuses selection, so this read is stable
  assign rd_byte = mem[addr];
  assign rd_pos = eeprom_pkg::BIT_LAST - bit_cnt;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_addr = addr;
    next_col0 = col0;
    next_wr_cnt = wr_cnt;
    next_ack = ack;
    next_start_seen = start_seen;
    next_done_seen = done_seen;
    buf_we = 1'b0;
    if (done_s != done_seen) begin
      next_done_seen = done_s;
      next_wr_cnt = '0;
    end
    if (start_tog != start_seen) begin
      // Start toggled half a clock before this edge; protocol keeps it settled
      next_start_seen = start_tog; // see RULE_10
      next_state = eeprom_pkg::st_select;
      next_shift = {7'h00, sda_in};
      next_bit_cnt = 4'h1;
      next_ack = 1'b0;
    end else if (state != eeprom_pkg::st_idle) begin
      if (bit_cnt == eeprom_pkg::BIT_ACK) begin
        next_bit_cnt = 4'h0;
        if (state == eeprom_pkg::st_read) begin
          if (sda_in) begin
            next_state = eeprom_pkg::st_idle;
          end else begin
            next_addr = addr + 15'h0001;
          end
        end else if (!ack) begin
          next_state = eeprom_pkg::st_idle;
        end else begin
          case (state)
            eeprom_pkg::st_select: begin
              next_state = shift[0] ? eeprom_pkg::st_read : eeprom_pkg::st_addr_hi; // see RULE_13
            end
            eeprom_pkg::st_addr_hi: begin
              next_state = eeprom_pkg::st_addr_lo;
            end
            eeprom_pkg::st_addr_lo: begin
              next_state = eeprom_pkg::st_write;
            end
            default: begin
              next_state = state;
            end
          endcase
        end
      end else begin
        next_bit_cnt = bit_cnt + 4'h1;
        next_shift = got;
        if (bit_cnt == eeprom_pkg::BIT_LAST) begin
          case (state)
            eeprom_pkg::st_select: begin
              next_ack = (got[7:4] == eeprom_pkg::DEV_CODE) && (got[3:1] == strap_s) // see RULE_03
                && (wr_cnt == '0); // see RULE_14
            end
            eeprom_pkg::st_addr_hi: begin
              next_addr[14:8] = got[6:0]; // see RULE_07
              next_ack = 1'b1;
            end
            eeprom_pkg::st_addr_lo: begin
              next_addr[7:0] = got;
              next_col0 = got[5:0];
              next_ack = 1'b1;
            end
            eeprom_pkg::st_write: begin
              buf_we = 1'b1; // see RULE_08
              next_addr[5:0] = addr[5:0] + 6'h01; // see RULE_15
              if (wr_cnt != eeprom_pkg::FULL_PAGE) begin
                next_wr_cnt = wr_cnt + 7'h01;
              end
              next_ack = 1'b1;
            end
            default: begin
              next_ack = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= eeprom_pkg::st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr <= '0;
      col0 <= '0;
      wr_cnt <= '0;
      ack <= 1'b0;
      start_seen <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      addr <= next_addr;
      col0 <= next_col0;
      wr_cnt <= next_wr_cnt;
      ack <= next_ack;
      start_seen <= next_start_seen;
      done_seen <= next_done_seen;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (buf_we) begin
      page_buf[addr[5:0]] <= got;
    end
  end

  // Output side of the link: the line changes only while the clock is low
  always_comb begin
    next_sda_oe = 1'b0;
    if (state == eeprom_pkg::st_read) begin
      if (bit_cnt != eeprom_pkg::BIT_ACK) begin
        next_sda_oe = ~rd_byte[rd_pos[2:0]];
      end
    end else if (state != eeprom_pkg::st_idle && bit_cnt == eeprom_pkg::BIT_ACK && ack) begin
      next_sda_oe = 1'b1; // see RULE_12
    end
  end

  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= next_sda_oe; // see RULE_01
    end
  end

  // System domain
  logic stop_s1, stop_s2, stop_s3;
  logic wp_s1, wp_s;
  logic next_done_tog;

  // A floating protect pin is pulled low at the pad and arrives here as low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_s1 <= 1'b0;
      stop_s2 <= 1'b0;
      stop_s3 <= 1'b0;
      wp_s1 <= 1'b0;
      wp_s <= 1'b0;
    end else begin
      stop_s1 <= stop_tog;
      stop_s2 <= stop_s1;
      stop_s3 <= stop_s2;
      wp_s1 <= write_protect; // see RULE_06
      wp_s <= wp_s1;
    end
  end

  // Count, column and page are link registers held still after the stop
  assign pif.start = stop_s2 ^ stop_s3; // see RULE_11
  assign pif.protect = wp_s; // see RULE_05
  assign pif.count = wr_cnt;
  assign pif.col0 = col0;
  assign pif.page = addr[14:6];
  assign pif.wdata = page_buf[pif.widx];

  prog_engine #(
    .PROG_CYCLES(PROG_CYCLES)
  ) engine (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pif(pif)
  );

  always_ff @(posedge clk_sys) begin
    if (pif.we) begin
      mem[pif.waddr] <= pif.wdata; // see RULE_09
    end
  end

  assign next_done_tog = done_tog ^ pif.done;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_tog <= 1'b0;
      write_busy <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      done_tog <= next_done_tog;
      write_busy <= pif.busy;
      // Never drives high; only the enable moves the line
      sda_out <= 1'b0; // see RULE_02
    end
  end
endmodule
`default_nettype wire

// >>> eeprom_target_sva.sv
// Purpose: Concurrent checks on the pins of the serial memory target.
// Assumes: Bound to every eeprom_target instance.
// Notes: Busy length is counted in helper logic.
`timescale 1ns/1ps
`default_nettype none
module eeprom_target_sva #(
  parameter int PROG_CYCLES = eeprom_pkg::WR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic sda_in,
  input wire logic select_strap_msb,
  input wire logic select_strap_mid,
  input wire logic select_strap_lsb,
  input wire logic write_protect,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy
);
  int cnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else cnt <= write_busy ? cnt + 1 : 0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !sda_oe && !write_busy)
    else $error("outputs active in reset");
  sda_out_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  oe_edge_low_a: assert property ($changed(sda_oe) |-> !serial_clk)
    else $error("data pull changed with clock high");
  oe_hold_high_a: assert property (serial_clk && $past(serial_clk) |-> $stable(sda_oe))
    else $error("data pull moved during clock high");
  busy_no_ack_a: assert property (write_busy |-> !sda_oe)
    else $error("line pulled while programming");
  busy_idle_a: assert property ($rose(write_busy) |-> serial_clk && sda_in)
    else $error("programming began before stop");
  busy_min_a: assert property ($rose(write_busy) |-> write_busy [*8])
    else $error("programming too short");
  busy_len_a: assert property ($fell(write_busy) |-> cnt == PROG_CYCLES)
    else $error("programming length wrong");
  busy_max_a: assert property (cnt <= PROG_CYCLES)
    else $error("programming overran");
endmodule
bind eeprom_target eeprom_target_sva #(.PROG_CYCLES(PROG_CYCLES)) eeprom_target_sva_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk), .sda_in(sda_in),
  .select_strap_msb(select_strap_msb), .select_strap_mid(select_strap_mid),
  .select_strap_lsb(select_strap_lsb), .write_protect(write_protect),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
`default_nettype wire

// >>> prog_engine.sv
// Purpose: Self-timed programming cycle that copies a page buffer into the array.
// Assumes: start is a one-cycle pulse on clk_sys after a stop condition.
// Notes: Bytes are copied in the first cycles; busy then runs out the full time.
`timescale 1ns/1ps
`default_nettype none
module prog_engine #(
  parameter int PROG_CYCLES = eeprom_pkg::WR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  prog_if.engine pif
);
  localparam eeprom_pkg::timer_t TIMER_LAST = eeprom_pkg::timer_t'(PROG_CYCLES - 1);

  eeprom_pkg::prog_state_e state, next_state;
  eeprom_pkg::timer_t timer, next_timer;
  eeprom_pkg::count_t n, next_n;
  eeprom_pkg::col_t next_widx;
  logic next_busy, next_done, next_we;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_n = n;
    next_busy = pif.busy;
    next_done = 1'b0;
    next_we = 1'b0;
    next_widx = pif.widx;
    case (state)
      eeprom_pkg::prog_idle: begin
        if (pif.start && pif.count != '0) begin
          if (pif.protect) begin
            next_done = 1'b1; // see RULE_05
          end else begin
            next_state = eeprom_pkg::prog_run;
            next_busy = 1'b1;
            next_timer = '0;
            next_n = '0;
          end
        end
      end
      eeprom_pkg::prog_run: begin
        if (n != pif.count) begin
          next_we = 1'b1;
          next_widx = pif.col0 + n[eeprom_pkg::COL_W-1:0]; // see RULE_15
          next_n = n + 7'h01;
        end
        next_timer = timer + 18'h00001;
        if (timer == TIMER_LAST) begin
          next_state = eeprom_pkg::prog_idle;
          next_busy = 1'b0;
          next_done = 1'b1; // see RULE_09
        end
      end
      default: begin
        next_state = eeprom_pkg::prog_idle;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= eeprom_pkg::prog_idle;
      timer <= '0;
      n <= '0;
      pif.busy <= 1'b0;
      pif.done <= 1'b0;
      pif.we <= 1'b0;
      pif.widx <= '0;
      pif.waddr <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      n <= next_n;
      pif.busy <= next_busy;
      pif.done <= next_done;
      pif.we <= next_we;
      pif.widx <= next_widx;
      pif.waddr <= {pif.page, next_widx};
    end
  end
endmodule
`default_nettype wire

// >>> prog_if.sv
// Purpose: Carries a committed page from the link side to the programming engine.
// Assumes: All signals live in the clk_sys domain or are quasi-static while used.
// Notes: count, col0 and page are held steady by the link side while programming runs.
`timescale 1ns/1ps
`default_nettype none
interface prog_if;
  logic start;
  logic protect;
  logic [eeprom_pkg::COUNT_W-1:0] count;
  logic [eeprom_pkg::COL_W-1:0] col0;
  logic [eeprom_pkg::PAGE_W-1:0] page;
  logic [7:0] wdata;
  logic busy;
  logic done;
  logic we;
  logic [eeprom_pkg::ADDR_W-1:0] waddr;
  logic [eeprom_pkg::COL_W-1:0] widx;
  modport engine (
    input start, protect, count, col0, page, wdata,
    output busy, done, we, waddr, widx
  );
  modport owner (
    output start, protect, count, col0, page, wdata,
    input busy, done, we, waddr, widx
  );
endinterface
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the serial memory target.
// Assumes: Programming shortened to 200 cycles.
// Notes: Array model holds only bytes written with protect low.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b1;
  logic [2:0] strap = 3'h0;
  logic write_protect = 1'b0;
  logic serial_clk, sda_low, sda_oe, sda_out, write_busy, sda, ack;
  logic [7:0] q;
  logic [14:0] page_base;
  logic [7:0] mem [int];
  int errors = 0;
  int total_checks = 0;
  // Full page first, so no later read meets an unwritten array byte
  int cols[3] = '{0, 62, 5};
  int lens[3] = '{66, 4, 3};
  assign sda = !(sda_oe | sda_low);
  always #12.5 clk_sys = !clk_sys;
  eeprom_target #(.PROG_CYCLES(200)) eeprom_target_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk), .sda_in(sda),
    .select_strap_msb(strap[2]), .select_strap_mid(strap[1]), .select_strap_lsb(strap[0]),
    .write_protect(write_protect), .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
  two_wire_ctl two_wire_ctl_inst (.sda(sda), .scl(serial_clk), .sda_low(sda_low));
  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] sel_byte(input logic [2:0] a, input logic rd);
    return {eeprom_pkg::DEV_CODE, a, rd};
  endfunction
  task automatic put(input logic [7:0] d, output logic a);
    logic [7:0] r;
    two_wire_ctl_inst.xfer(d, 1'b0, r, a);
  endtask
  task automatic write_page(input logic [14:0] a, input int n);
    logic k;
    logic [7:0] d;
    two_wire_ctl_inst.start_cond();
    put(sel_byte(strap, 1'b0), k);
    chk_bit(k, 1'b1, "write select");
    put({1'b1, a[14:8]}, k);
    chk_bit(k, 1'b1, "addr ack");
    put(a[7:0], k);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      put(d, k);
      chk_bit(k, 1'b1, "data ack");
      if (!write_protect) mem[{a[14:6], 6'(a[5:0] + i)}] = d;
    end
    two_wire_ctl_inst.stop_cond();
  endtask
  task automatic read_at(input logic [14:0] a, input int n);
    logic k;
    logic [7:0] r;
    two_wire_ctl_inst.start_cond();
    put(sel_byte(strap, 1'b0), k);
    put({1'b0, a[14:8]}, k);
    put(a[7:0], k);
    two_wire_ctl_inst.start_cond();
    put(sel_byte(strap, 1'b1), k);
    chk_bit(k, 1'b1, "read select");
    for (int i = 0; i < n; i++) begin
      two_wire_ctl_inst.xfer({7'h00, i == n - 1}, 1'b1, r, k);
      if (mem.exists(15'(a + i))) chk_byte(r, mem[15'(a + i)]);
    end
    two_wire_ctl_inst.stop_cond();
  endtask
  // Protected writes do not run the timer, so busy is checked only when programming
  task automatic wait_ready(input logic busy_exp);
    logic k;
    repeat (10) @(posedge clk_sys);
    if (busy_exp) chk_bit(write_busy, 1'b1, "busy after stop");
    for (int t = 0; t < 20; t++) begin
      two_wire_ctl_inst.start_cond();
      put(sel_byte(strap, 1'b0), k);
      two_wire_ctl_inst.stop_cond();
      if (t == 0 && busy_exp) chk_bit(k, 1'b0, "poll while busy");
      if (k) break;
      repeat (100) @(posedge clk_sys);
    end
    chk_bit(k, 1'b1, "ready after write");
  endtask
  initial begin
    void'($urandom(32'ha3189608));
    // Start high so the link-side async flops see a real falling edge of reset
    #2 rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    page_base = {9'($urandom), 6'h00};
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      #2 write_protect = (k == 2);
      write_page(page_base | 15'(cols[k]), lens[k]);
      wait_ready(k < 2);
      read_at(page_base, 64);
      $display("page test %0d done", k);
    end
    // After the page tests the current address holds a known byte: last column of the page
    // Second pass uses all-low straps, as floating straps read
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_sys);
      #2 strap = r ? 3'h0 : 3'($urandom);
      for (int c = 0; c < 9; c++) begin
        two_wire_ctl_inst.start_cond();
        put(c < 8 ? sel_byte(3'(c), 1'b1) : {4'h5, strap, 1'b1}, ack);
        chk_bit(ack, c < 8 && 3'(c) == strap, "select match");
        if (ack) begin
          two_wire_ctl_inst.xfer(8'h01, 1'b1, q, ack);
          chk_byte(q, mem[15'(page_base + 15'h003f)]);
        end
        two_wire_ctl_inst.stop_cond();
      end
      $display("select test %0d done", r);
    end
    end_of_test();
  end
  // Whole run needs well under a millisecond
  initial begin
    #2000000;
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> two_wire_ctl.sv
// Purpose: Behavioural bus controller that makes the serial clock and data.
// Assumes: Data wire is resolved outside with a pull-up.
// Notes: Clock stands high between frames; one bit takes 80 ns.
`timescale 1ns/1ps
`default_nettype none
module two_wire_ctl (
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Also serves as repeated start from clock low
  task automatic start_cond();
    if (!scl) begin
      #20 sda_low = 1'b0;
      #20 scl = 1'b1;
    end
    #20 sda_low = 1'b1;
    #20 scl = 1'b0;
  endtask
  task automatic stop_cond();
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40;
  endtask
  // Data only moves with clock low; on reads d[0] high means no acknowledge
  task automatic xfer(input logic [7:0] d, input logic rd, output logic [7:0] q, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_low = (rd == (i == 0)) ? !d[(i == 0) ? 0 : i - 1] : 1'b0;
      #20 scl = 1'b1;
      if (i > 0) q[i - 1] = sda;
      else ack = !sda;
      #40 scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
